// >>> hdl/exec_regs.vh
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH
// opcode field positions and patterns (14-bit instruction word)
`define OP_HI          13
`define OP_LO          8
`define OP_DEST_BIT    7
`define OP_ADDR_HI     6
`define OP_ADDR_LO     0
`define OP_LIT_HI      7
`define OP_LIT_LO      0
// upper six bits of each handled instruction
`define OPC_OR_FILE    6'h04
`define OPC_MOVE_FILE  6'h08
`define OPC_MOVE_WORK  6'h00
// literal load: top four bits 1100, bits 9:8 are don't care
`define OPC_LOAD_LIT4  4'hC
// quarter phase codes
`define PH_DECODE      2'h0
`define PH_READ        2'h1
`define PH_PROCESS     2'h2
`define PH_WRITE       2'h3
// reset values
`define WORK_RESET     8'h00
`endif

// >>> hdl/quarter_phase.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"
// four quarter phase sequencer, one phase per enabled clock
module quarter_phase
(
  input  wire       clock_i,
  input  wire       nrst_i,
  input  wire       step_i,
  output reg  [1:0] phase_o
);
  // phases wrap decode, read, process, write
  always @(posedge clock_i)
  begin
    if (!nrst_i)
      phase_o <= `PH_DECODE;
    else if (step_i)
      phase_o <= phase_o + 2'h1;
  end
endmodule // quarter_phase
`default_nettype wire

// >>> hdl/or_and_move_instruction_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"
module or_and_move_instruction_exec
(
  input  wire        clock_i,
  input  wire        nrst_i,
  input  wire        step_i,
  input  wire [13:0] instr_i,
  input  wire [7:0]  file_rdata_i,
  output reg  [1:0]  phase_o,
  output reg         file_re_o,
  output reg         file_we_o,
  output reg  [6:0]  file_addr_o,
  output reg  [7:0]  file_wdata_o,
  output reg  [7:0]  work_o,
  output reg         zero_o,
  output reg         illegal_o
);
  localparam K_NONE = 3'h0;
  localparam K_OR   = 3'h1;
  localparam K_MOVE_FILE_TO_DEST = 3'h2;
  localparam K_MOVW = 3'h3;
  localparam K_LIT  = 3'h4;

  wire [1:0] phase;
  reg  [2:0] kind_r;
  reg  [13:0] ir_r;
  reg  [7:0] operand_r;
  reg  [7:0] result_r;
  reg  [2:0] kind_nxt;

  // next values chosen by the combinational quarter logic
  reg  [7:0] result_nxt;
  reg  [7:0] work_nxt;
  reg        zero_nxt;
  reg        we_nxt;
  reg  [7:0] wdata_nxt;
  reg        re_nxt;

  // helpers for the decode, read and write quarters
  wire [7:0] operand_nxt;
  wire       illegal_nxt;
  wire       result_zero;

  quarter_phase u_phase
  (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .step_i  (step_i),
    .phase_o (phase)
  );

  // widths of the datapath and of the file address
  localparam DATA_W = 8;
  localparam ADDR_W = 7;

  // fields of the incoming word, split once so the decode reads plainly
  wire [5:0]        opc_top;
  wire [3:0]        opc_lit;
  wire              dest_in;
  wire [ADDR_W-1:0] addr_in;
  assign opc_top = instr_i[`OP_HI:`OP_LO];
  assign opc_lit = instr_i[13:10];
  assign dest_in = instr_i[`OP_DEST_BIT];
  assign addr_in = instr_i[`OP_ADDR_HI:`OP_ADDR_LO];

  // fields of the held word, read by the later quarters
  wire       dest_held;
  wire [7:0] lit_held;
  assign dest_held = ir_r[`OP_DEST_BIT];
  assign lit_held  = ir_r[`OP_LIT_HI:`OP_LIT_LO];

  // classify the incoming word; a store with the select bit clear is a no-op
  always @*
  begin
    kind_nxt = K_NONE;
    case (opc_top)
      `OPC_OR_FILE:
        kind_nxt = K_OR;
      `OPC_MOVE_FILE:
        kind_nxt = K_MOVE_FILE_TO_DEST;
      `OPC_MOVE_WORK:
        if (dest_in)
          kind_nxt = K_MOVW;
      default:
        if (opc_lit == `OPC_LOAD_LIT4)
          kind_nxt = K_LIT;
    endcase
  end

  // decode quarter fetch: every kind that names a file register reads it
  always @*
  begin
    case (kind_nxt)
      K_OR, K_MOVE_FILE_TO_DEST, K_MOVW:
        re_nxt = 1'b1;
      default:
        re_nxt = 1'b0;
    endcase
  end

  // unknown words still walk all four quarters, but change nothing
  assign illegal_nxt = (kind_nxt == K_NONE);

  // read quarter source: the literal rides in the word, the rest come from the file
  assign operand_nxt = (kind_r == K_LIT) ? lit_held : file_rdata_i;

  // per bit inclusive or of work and the fetched operand
  genvar gi;
  wire [DATA_W-1:0] or_bits;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1)
    begin : g_or_bit
      assign or_bits[gi] = work_o[gi] | operand_r[gi];
    end
  endgenerate

  // process quarter value; the or and the store of work to a file read the working register
  always @*
  begin
    result_nxt = 8'h00;
    case (kind_r)
      K_OR:    result_nxt = or_bits;
      K_MOVE_FILE_TO_DEST:  result_nxt = operand_r;
      K_MOVW:  result_nxt = work_o;
      K_LIT:   result_nxt = operand_r;
      default: result_nxt = 8'h00;
    endcase
  end

  // zero test of the processed value, ready before the write quarter
  assign result_zero = (result_r == 8'h00);

  // write quarter targets; whatever the kind does not name keeps its value
  always @*
  begin
    work_nxt  = work_o;
    zero_nxt  = zero_o;
    we_nxt    = 1'b0;
    wdata_nxt = file_wdata_o;
    case (kind_r)
      K_OR, K_MOVE_FILE_TO_DEST:
      begin
        zero_nxt = result_zero;
        if (dest_held)
        begin
          // with the move this rewrite leaves the data as it was
          we_nxt    = 1'b1;
          wdata_nxt = result_r;
        end
        else
          work_nxt = result_r;
      end
      K_MOVW:
      begin
        we_nxt    = 1'b1;  // flag untouched
        wdata_nxt = result_r;
      end
      K_LIT:
        work_nxt = result_r;  // flag untouched
      default:
        work_nxt = work_o;  // unhandled words act as no operation
    endcase
  end

  // quarter phase datapath; step_i paces the phases so a full cycle is four steps
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      kind_r       <= K_NONE;
      ir_r         <= 14'h0000;
      operand_r    <= 8'h00;
      result_r     <= 8'h00;
      phase_o      <= `PH_DECODE;
      file_re_o    <= 1'b0;
      file_we_o    <= 1'b0;
      file_addr_o  <= 7'h00;
      file_wdata_o <= 8'h00;
      work_o       <= `WORK_RESET;
      zero_o       <= 1'b0;
      illegal_o    <= 1'b0;
    end
    else
    begin
      file_we_o <= 1'b0;
      file_re_o <= 1'b0;
      if (step_i)
      begin
        phase_o <= phase + 2'h1;
        case (phase)
          `PH_DECODE:
          begin
            // decode quarter latches the word
            ir_r        <= instr_i;
            kind_r      <= kind_nxt;
            illegal_o   <= illegal_nxt;
            file_addr_o <= addr_in;
            file_re_o   <= re_nxt;
          end
          `PH_READ:
          begin
            // read quarter samples the operand
            operand_r <= operand_nxt;
          end
          `PH_PROCESS:
          begin
            // process quarter forms the result
            result_r <= result_nxt;
          end
          `PH_WRITE:
          begin
            // write quarter; file writes pulse one clock
            work_o       <= work_nxt;
            zero_o       <= zero_nxt;
            file_we_o    <= we_nxt;
            file_wdata_o <= wdata_nxt;
          end
          default:
            phase_o <= `PH_DECODE;
        endcase
      end
    end
  end
endmodule // or_and_move_instruction_exec
`default_nettype wire

// >>> bench/exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module exec_props (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       step_i,
  input wire logic [1:0] phase_o,
  input wire logic       file_re_o,
  input wire logic       file_we_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_phase_step:
    assert property (step_i |=> phase_o == $past(phase_o) + 2'h1) else $error("phase");
  a_read_phase: assert property (file_re_o |-> phase_o == 2'h1) else $error("read");
  a_read_once: assert property (file_re_o |=> !file_re_o) else $error("read");
  a_write_last: assert property (file_we_o |-> phase_o == 2'h0) else $error("write");
  a_write_once: assert property (file_we_o |=> !file_we_o) else $error("write");
  c_read: cover property (file_re_o);
  c_write: cover property (file_we_o);
  c_wrap: cover property (phase_o == 2'h3);
endmodule // exec_props
bind or_and_move_instruction_exec exec_props u_props (
  .clock_i   (clock_i),
  .nrst_i    (nrst_i),
  .step_i    (step_i),
  .phase_o   (phase_o),
  .file_re_o (file_re_o),
  .file_we_o (file_we_o)
);
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock_i = 1'b0, nrst_i = 1'b0, step_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0]  file_rdata_i = 8'h00;
  wire  [1:0]  phase_o;
  wire  [6:0]  file_addr_o;
  wire  [7:0]  file_wdata_o, work_o;
  wire         file_re_o, file_we_o, zero_o, illegal_o;
  int          errors = 0, samples_checked = 0;
  or_and_move_instruction_exec uut (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .step_i       (step_i),
    .instr_i      (instr_i),
    .file_rdata_i (file_rdata_i),
    .phase_o      (phase_o),
    .file_re_o    (file_re_o),
    .file_we_o    (file_we_o),
    .file_addr_o  (file_addr_o),
    .file_wdata_o (file_wdata_o),
    .work_o       (work_o),
    .zero_o       (zero_o),
    .illegal_o    (illegal_o)
  );
  always #5 clock_i = ~clock_i;
  task chk(input logic [7:0] s, e);
    samples_checked++;
    errors += int'(s !== e);
    if (s !== e) $display("BAD %0t %h %h", $time, s, e);
  endtask
  // outputs settle just past the write edge
  task run(input logic [13:0] i, input logic [7:0] d = 8'h00);
    @(posedge clock_i);
    instr_i <= i;
    file_rdata_i <= d;
    step_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    step_i <= 1'b0;
    #1;
  endtask
  task t_or;
    run(14'h3000);
    run(14'h0405);
    chk(work_o, 8'h00);
    chk(zero_o, 8'h01);
    chk(illegal_o, 8'h00);
    run(14'h3091);
    run(14'h0412, 8'h13);
    chk(work_o, 8'h93);
    chk(zero_o, 8'h00);
    chk(file_we_o, 8'h00);
    chk(file_addr_o, 8'h12);
    run(14'h04A5);
    chk(file_wdata_o, 8'h93);
    chk(file_we_o, 8'h01);
    chk(file_addr_o, 8'h25);
    chk(work_o, 8'h93);
    chk(phase_o, 8'h00);
  endtask
  task t_move;
    run(14'h08FF);
    chk(file_we_o, 8'h01);
    chk(file_wdata_o, 8'h00);
    chk(work_o, 8'h93);
    chk(zero_o, 8'h01);
    run(14'h304F);
    run(14'h0081);
    chk(file_wdata_o, 8'h4F);
    chk(file_we_o, 8'h01);
    chk(file_addr_o, 8'h01);
    chk(zero_o, 8'h01);
    run(14'h0803, 8'h80);
    chk(work_o, 8'h80);
    chk(zero_o, 8'h00);
    chk(file_we_o, 8'h00);
  endtask
  // unknown word is a no-op; literal load ignores bits 9:8 and the flag
  task t_illegal;
    run(14'h0000, 8'hFF);
    chk(illegal_o, 8'h01);
    chk(work_o, 8'h80);
    chk(file_we_o, 8'h00);
    chk(zero_o, 8'h00);
    run(14'h3300);
    chk(illegal_o, 8'h00);
    chk(work_o, 8'h00);
    chk(zero_o, 8'h00);
  endtask
  // hang guard
  initial
  begin
    repeat (300) @(posedge clock_i);
    errors++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_or();
    t_move();
    t_illegal();
    summarize();
  end
  task summarize;
    $display("counts %0d %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
endmodule // tb
`default_nettype wire
